//--- dv/dspx_host.sv
// wishbone classic host model that owns the core register bus
`timescale 1ns/1ps
`default_nettype none
module dspx_host (
  // clock
  input wire logic clk_sys_i,
  // bus request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o,
  // bus answer
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  // bus idle from time zero so reset sees no stray request
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
    sel_o = 4'h0;
  end

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk_sys_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'hf;
    do @(posedge clk_sys_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d; // stale data must not look valid
  endtask : xfer
endmodule : dspx_host
`default_nettype wire

//--- dv/tb_dsp_core_instruction_subset.sv
// self-checking bench for the dsp instruction subset core
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_core_instruction_subset;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cyc, stb, we, ack, busy, slp, idl;
  logic wdt = 1'b0;
  logic wake = 1'b0;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, nb;
  logic [3:0] sel;
  int n_fail = 0;
  int num_checks = 0;
  int ncyc = 0;

  dspx_core #(.AW(8)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wdt_timeout_i(wdt), .wake_i(wake), .busy_o(busy),
    .sleep_o(slp), .idle_o(idl));
  dspx_host u_host (.clk_sys_i(clk_sys_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel), .dat_i(rdat), .ack_i(ack));

  // 20 MHz clock
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // busy cycle count and hang guard
  always @(posedge clk_sys_i) begin
    if (busy === 1'b1) nb <= nb + 32'h1;
    ncyc <= ncyc + 1;
    if (ncyc == 6000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // start a command and measure how long busy stands
  task automatic run(input logic [31:0] c, input int n);
    nb = 32'h0;
    wr(dspx_pkg::REG_CMD, c);
    while (busy !== 1'b0) @(posedge clk_sys_i);
    chk("busy cycles", nb, 32'(n + 1));
  endtask : run

  // command word, destination field always the Wd form
  function automatic logic [31:0] cm(input logic [4:0] op, input logic [3:0] ra, rb, rd,
      input logic [3:0] fl);
    return {fl, 8'h00, rd, rb, ra, 2'h2, 1'b0, op};
  endfunction : cm

  // 32-bit product with per-operand signedness
  function automatic logic [31:0] mx(input logic [15:0] a, b, input logic sa, sb);
    logic signed [16:0] x, y;
    x = {sa & a[15], a};
    y = {sb & b[15], b};
    return 32'(x * y);
  endfunction : mx

  initial begin
    logic [31:0] q, a, b, e;
    logic c;
    void'($urandom(44));
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(dspx_pkg::REG_SP, q);
    chk("stack ptr reset", q, 32'h80);
    rd(8'h2c, q);
    chk("unmapped read", q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      a = (i == 3) ? 32'h8000 : ($urandom & 32'hffff);
      b = (i == 3) ? 32'hffff : ((i < 4) ? ($urandom & 32'hffff) : ($urandom & 32'h1f));
      if (i == 7) b = 32'h1f;
      wr(8'h44, a);
      wr(8'h50, b);
      wr(dspx_pkg::REG_LIT, b);
      run(cm((i < 4) ? 5'h04 : 5'h05, 4'h1, 4'h4, 4'h6, {2'b00, i[0], i[1] & (i < 4)}), 1);
      e = mx(a[15:0], b[15:0], i[0], i[1] & (i < 4));
      rd(8'h58, q);
      chk("product low", {16'h0, q[15:0]}, {16'h0, e[15:0]});
      rd(8'h5c, q);
      chk("product high", {16'h0, q[15:0]}, {16'h0, e[31:16]});
    end
    // stack: single and double forms, then repeats
    a = $urandom & 32'hffff;
    b = $urandom & 32'hffff;
    wr(8'h48, 32'h1234);
    wr(8'h50, a);
    wr(8'h54, b);
    run(cm(5'h08, 4'h2, 4'h0, 4'h0, 4'h0), 1);
    run(cm(5'h0c, 4'h4, 4'h0, 4'h0, 4'h0), 2);
    run(cm(5'h0b, 4'h0, 4'h0, 4'h8, 4'h0), 2);
    rd(8'h60, q);
    chk("double pop low", {16'h0, q[15:0]}, a);
    rd(8'h64, q);
    chk("double pop high", {16'h0, q[15:0]}, b);
    run(cm(5'h0a, 4'h0, 4'h0, 4'ha, 4'h0), 1);
    rd(8'h68, q);
    chk("single pop", {16'h0, q[15:0]}, 32'h1234);
    wr(dspx_pkg::REG_LIT, 32'h2);
    run(cm(5'h0e, 4'h0, 4'h0, 4'h0, 4'h0), 1);
    run(cm(5'h08, 4'h2, 4'h0, 4'h0, 4'h0), 5);
    rd(dspx_pkg::REG_SP, q);
    chk("sp after repeat lit", q, 32'h83);
    wr(8'h44, 32'h1);
    run(cm(5'h0f, 4'h1, 4'h0, 4'h0, 4'h0), 1);
    run(cm(5'h0a, 4'h0, 4'h0, 4'ha, 4'h0), 3);
    rd(dspx_pkg::REG_SP, q);
    chk("sp after repeat reg", q, 32'h81);
    for (int j = 0; j < 2; j++) begin
      e = $urandom & 32'h3ff;
      wr(dspx_pkg::REG_LIT, e);
      run(cm(5'h10, 4'h0, 4'h0, 4'h5, {j[0], 3'b000}), 3 - j);
      rd(8'h54, q);
      chk("return literal", {16'h0, q[15:0]}, e);
    end
    // rotates, carry tracked here; corner 0x8000 first
    c = 1'b0;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 32'h8000 : ($urandom & 32'hffff);
      wr(8'h44, a);
      run(cm(5'h11 + 5'(i), 4'h1, 4'h0, 4'h3, 4'h0), 1);
      e = (i == 2) ? {16'h0, c, a[15:1]} : {16'h0, a[14:0], (i == 0) ? c : a[15]};
      if (i != 1) c = (i == 0) ? a[15] : a[0];
      rd(8'h4c, q);
      chk("rotate result", {16'h0, q[15:0]}, e);
      rd(dspx_pkg::REG_STAT, q);
      chk("rotate flags", {29'h0, q[3:1]}, {29'h0, e == 32'h0, e[15], c});
    end
    // accumulator forms on small operands, no saturation
    a = $urandom & 32'hff;
    b = $urandom & 32'hff;
    wr(8'h44, a);
    wr(8'h50, b);
    for (int i = 0; i < 4; i++) begin
      run(cm((i == 1) ? 5'h03 : ((i == 2) ? 5'h01 : ((i == 3) ? 5'h02 : 5'h00)),
        4'h1, 4'h4, 4'h0, 4'h0), 1);
      e = (i == 0) ? a * b : ((i == 1) ? 32'h0 : ((i == 2) ? a * a : -(a * b)));
      rd(dspx_pkg::REG_ACCA_LO, q);
      chk("accumulator", q, e);
    end
    // square into accumulator b, acc select bit 5
    run(cm(5'h01, 4'h1, 4'h0, 4'h0, 4'h0) | 32'h20, 1);
    rd(dspx_pkg::REG_ACCB_LO, q);
    chk("square acc b", q, a * a);
    // file register forms: push W1, pop into file 0x10, rotate file into W0
    wr(dspx_pkg::REG_FILE, 32'h10);
    run(cm(5'h08, 4'h1, 4'h0, 4'h0, 4'h0), 1);
    run(cm(5'h09, 4'h0, 4'h0, 4'h0, 4'h0), 1);
    run(cm(5'h12, 4'h0, 4'h0, 4'h0, 4'h0) ^ 32'hc0, 1);
    rd(8'h40, q);
    chk("rotate file to w0", {16'h0, q[15:0]}, {16'h0, a[14:0], a[15]});
    // watchdog flag, sleep, wake, idle
    @(posedge clk_sys_i) wdt <= 1'b1;
    @(posedge clk_sys_i) wdt <= 1'b0;
    wr(dspx_pkg::REG_LIT, 32'h0);
    run(cm(5'h0d, 4'h0, 4'h0, 4'h0, 4'h0), 1);
    chk("sleep out", {31'h0, slp}, 32'h1);
    rd(dspx_pkg::REG_STAT, q);
    chk("watchdog_timeout_flag and sleep flag", {30'h0, q[12], q[10]}, 32'h1);
    @(posedge clk_sys_i) wake <= 1'b1;
    @(posedge clk_sys_i) wake <= 1'b0;
    @(posedge clk_sys_i);
    chk("sleep after wake", {31'h0, slp}, 32'h0);
    wr(dspx_pkg::REG_LIT, 32'h1);
    run(cm(5'h0d, 4'h0, 4'h0, 4'h0, 4'h0), 1);
    chk("idle out", {30'h0, idl, slp}, 32'h2);
    final_report();
  end
endmodule : tb_dsp_core_instruction_subset
`default_nettype wire

//--- rtl/dspx_core.sv
// instruction executor for the multiply, stack, repeat and rotate subset
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - accumulate_product puts Wm*Wn into the accumulator, one cycle, flags updated
// - square form multiplies Wm by itself into accumulator, same flags
// - accumulate_negated_product writes negated product, one cycle, no flag change
// - product_subtract_accumulate subtracts product, optional write-back, flags updated
// - integer_product gives 32-bit product into register pair, signedness per variant
// - literal integer_product multiplies register by 5-bit unsigned literal, no flags
// - single push or pop of file or working register, one cycle
// - double pop loads two working registers from stack in two cycles
// - double push stores two working registers onto stack in two cycles
// - power_save_entry literal picks sleep or idle, touches watchdog and sleep status
// - repeat by literal runs next instruction literal plus one times
// - repeat by register runs next instruction register plus one times
// - return_with_literal loads 10-bit literal and returns, three or two cycles
// - rotate_left_via_carry shifts carry in, old msb to carry, sets c n z
// - rotate_left_plain moves msb to bit 0, sets only n and z
// - rotate_right_via_carry shifts carry into msb, bit 0 to carry
module dspx_core #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // power and watchdog
  input wire logic wdt_timeout_i,
  input wire logic wake_i,
  output logic busy_o,
  output logic sleep_o,
  output logic idle_o
);
  function automatic logic [31:0] prod32(logic [15:0] a, logic [15:0] b, logic sa, logic sb);
    logic signed [16:0] x;
    logic signed [16:0] y;
    logic signed [33:0] p;
    x = {sa & a[15], a};
    y = {sb & b[15], b};
    p = x * y;
    return p[31:0];
  endfunction : prod32

  // 40-bit add or subtract that saturates; msb of result is the saturation event
  function automatic logic [40:0] addsat(logic [39:0] a, logic [31:0] p, logic sub);
    logic [40:0] s;
    logic [40:0] b;
    b = {{9{p[31]}}, p};
    s = sub ? ({a[39], a} - b) : ({a[39], a} + b);
    if (s[40] != s[39]) begin
      return {1'b1, s[40], {39{~s[40]}}};
    end
    return {1'b0, s[39:0]};
  endfunction : addsat

  function automatic logic ovf40(logic [39:0] v);
    return ~(&v[39:31] | ~|v[39:31]);
  endfunction : ovf40

  function automatic logic [31:0] be32(logic [31:0] o, logic [31:0] n, logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : be32

  function automatic logic [1:0] cyc_of(dspx_pkg::dspx_op_t op, logic short_ret);
    case (op)
      dspx_pkg::OP_POPD, dspx_pkg::OP_PUSHD: return dspx_pkg::CYC_TWO;
      dspx_pkg::OP_RETURN_WITH_LITERAL: return short_ret ? dspx_pkg::CYC_RET_SHORT : dspx_pkg::CYC_RET;
      default: return dspx_pkg::CYC_ONE;
    endcase
  endfunction : cyc_of

  dspx_pkg::dspx_state_t st_q, st_d;
  dspx_pkg::dspx_cmd_t cmd_q, cmd_d;
  dspx_pkg::dspx_flags_t fl_q, fl_d;
  logic [15:0] w_q [16];
  logic [15:0] w_d [16];
  logic [39:0] acca_q, acca_d, accb_q, accb_d;
  logic [13:0] lit_q, lit_d;
  logic [AW-1:0] file_q, file_d, sp_q, sp_d;
  logic [15:0] pc_q, pc_d, rep_q, rep_d;
  logic [1:0] cnt_q, cnt_d;
  logic ack_q, ack_d, busy_q, busy_d, sleep_q, sleep_d, idle_q, idle_d;
  logic slpf_q, slpf_d, watchdog_timeout_flag_q, watchdog_timeout_flag_d;
  logic [31:0] dat_q, dat_d;
  logic mem_en, mem_we;
  logic [AW-1:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [31:0] prod_mw, prod_sq, mul_res, rdv;
  logic [15:0] mul_a, mul_b, rot_src, rot_res;
  logic [3:0] rd1;
  logic first, last;

  dspx_mem #(.AW(AW), .DW(16)) u_mem (
    .clk_sys_i(clk_sys_i),
    .en_i(mem_en),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // operand paths shared by execution and checks
  always_comb begin
    first = (st_q == dspx_pkg::ST_EXEC) && (cnt_q == 2'h0);
    last = (st_q == dspx_pkg::ST_EXEC) && (cnt_q == cyc_of(cmd_q.op, cmd_q.ret_short) - 2'h1);
    rd1 = cmd_q.rd + 4'h1;
    prod_mw = prod32(w_q[cmd_q.ra], w_q[cmd_q.rb], 1'b1, 1'b1);
    prod_sq = prod32(w_q[cmd_q.ra], w_q[cmd_q.ra], 1'b1, 1'b1);
    mul_a = (cmd_q.op == dspx_pkg::OP_MULF) ? mem_rdata : w_q[cmd_q.ra];
    mul_b = w_q[cmd_q.rb];
    if (cmd_q.op == dspx_pkg::OP_MULL) mul_b = {11'h000, lit_q[4:0]};
    if (cmd_q.op == dspx_pkg::OP_MULF) mul_b = w_q[dspx_pkg::DEFAULT_WORKING_REGISTER_IDX];
    case (cmd_q.op)
      dspx_pkg::OP_MUL: mul_res = prod32(mul_a, mul_b, cmd_q.sgn_a, cmd_q.sgn_b);
      dspx_pkg::OP_MULL: mul_res = prod32(mul_a, mul_b, cmd_q.sgn_a, 1'b0);
      default: mul_res = prod32(mul_a, mul_b, 1'b0, 1'b0);
    endcase
    // register operand only for the Wd form, else the file register
    rot_src = (cmd_q.dst == dspx_pkg::DST_WD) ? w_q[cmd_q.ra] : mem_rdata;
    case (cmd_q.op)
      dspx_pkg::OP_RLC: rot_res = {rot_src[14:0], fl_q.c};
      dspx_pkg::OP_ROTATE_LEFT_PLAIN: rot_res = {rot_src[14:0], rot_src[15]};
      default: rot_res = {fl_q.c, rot_src[15:1]};
    endcase
  end

  // register read mux
  always_comb begin
    rdv = 32'h0000_0000;
    case (wb_adr_i)
      dspx_pkg::REG_CMD: rdv = cmd_q;
      dspx_pkg::REG_LIT: rdv = {18'h00000, lit_q};
      dspx_pkg::REG_FILE: rdv = {{(32-AW){1'b0}}, file_q};
      dspx_pkg::REG_STAT: rdv = {19'h00000, watchdog_timeout_flag_q, idle_q, slpf_q, fl_q, busy_q};
      dspx_pkg::REG_SP: rdv = {{(32-AW){1'b0}}, sp_q};
      dspx_pkg::REG_PC: rdv = {16'h0000, pc_q};
      dspx_pkg::REG_ACCA_LO: rdv = acca_q[31:0];
      dspx_pkg::REG_ACCA_HI: rdv = {24'h000000, acca_q[39:32]};
      dspx_pkg::REG_ACCB_LO: rdv = accb_q[31:0];
      dspx_pkg::REG_ACCB_HI: rdv = {24'h000000, accb_q[39:32]};
      dspx_pkg::REG_REP: rdv = {16'h0000, rep_q};
      default: if (wb_adr_i[7:6] == dspx_pkg::REG_WWIN) rdv = {16'h0000, w_q[wb_adr_i[5:2]]};
    endcase
  end

  // bus slave, executor and power state; executor writes win over the bus
  always_comb begin
    logic [40:0] ar;
    logic [39:0] cur;
    ar = 41'h0;
    cur = cmd_q.acc ? accb_q : acca_q;
    // state kept out of the concatenation, enum targets take only enum values
    st_d = st_q;
    {cmd_d, fl_d, acca_d, accb_d, lit_d, file_d} =
      {cmd_q, fl_q, acca_q, accb_q, lit_q, file_q};
    {sp_d, pc_d, rep_d, cnt_d, sleep_d, idle_d, slpf_d, watchdog_timeout_flag_d} =
      {sp_q, pc_q, rep_q, cnt_q, sleep_q, idle_q, slpf_q, watchdog_timeout_flag_q};
    w_d = w_q;
    ack_d = 1'b0;
    dat_d = dat_q;
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = sp_q;
    mem_wdata = 16'h0000;
    // single cycle ack, one wait state
    if (wb_cyc_i && wb_stb_i && !ack_q) begin
      ack_d = 1'b1;
      dat_d = rdv;
      if (wb_we_i) begin
        case (wb_adr_i)
          dspx_pkg::REG_CMD: if (st_q == dspx_pkg::ST_IDLE && |wb_sel_i) begin
            cmd_d = be32(cmd_q, wb_dat_i, wb_sel_i);
            st_d = dspx_pkg::ST_FETCH;
          end
          dspx_pkg::REG_LIT: lit_d = 14'(be32({18'h0, lit_q}, wb_dat_i, wb_sel_i));
          dspx_pkg::REG_FILE: file_d = AW'(be32(32'(file_q), wb_dat_i, wb_sel_i));
          dspx_pkg::REG_SP: sp_d = AW'(be32(32'(sp_q), wb_dat_i, wb_sel_i));
          dspx_pkg::REG_STAT: begin
            // write one to clear the sticky power flags
            if (wb_sel_i[1] && wb_dat_i[dspx_pkg::ST_SLEEPF]) slpf_d = 1'b0;
            if (wb_sel_i[1] && wb_dat_i[dspx_pkg::ST_WATCHDOG_TIMEOUT_FLAG]) watchdog_timeout_flag_d = 1'b0;
          end
          default: if (wb_adr_i[7:6] == dspx_pkg::REG_WWIN)
            w_d[wb_adr_i[5:2]] = 16'(be32({16'h0, w_q[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i));
        endcase
      end
    end
    if (wake_i) begin
      sleep_d = 1'b0;
      idle_d = 1'b0;
    end
    // operand fetch, one cycle ahead of execute for the registered memory
    if (st_q == dspx_pkg::ST_FETCH) begin
      mem_en = 1'b1;
      case (cmd_q.op)
        dspx_pkg::OP_POPF, dspx_pkg::OP_POPW, dspx_pkg::OP_POPD, dspx_pkg::OP_RETURN_WITH_LITERAL:
          mem_addr = sp_q - AW'(1);
        default: mem_addr = file_q;
      endcase
      st_d = dspx_pkg::ST_EXEC;
      cnt_d = 2'h0;
    end
    if (first) begin
      case (cmd_q.op)
        dspx_pkg::OP_MPY, dspx_pkg::OP_SQR, dspx_pkg::OP_MSC: begin
          if (cmd_q.op == dspx_pkg::OP_MSC) begin
            ar = addsat(cur, prod_mw, 1'b1);
            if (cmd_q.awb) w_d[dspx_pkg::AWB_IDX] = cmd_q.acc ? acca_q[31:16] : accb_q[31:16];
          end else begin
            ar = addsat(40'h0, cmd_q.op == dspx_pkg::OP_SQR ? prod_sq : prod_mw, 1'b0);
          end
          if (cmd_q.acc) begin
            accb_d = ar[39:0];
            fl_d.ob = ovf40(ar[39:0]);
            fl_d.sb = fl_q.sb | ar[40];
          end else begin
            acca_d = ar[39:0];
            fl_d.oa = ovf40(ar[39:0]);
            fl_d.sa = fl_q.sa | ar[40];
          end
          fl_d.acc_either_overflow = fl_d.oa | fl_d.ob;
          fl_d.acc_either_saturated = fl_d.sa | fl_d.sb;
        end
        dspx_pkg::OP_MPYN: begin
          // plain negation, no saturation and no flag update
          if (cmd_q.acc) accb_d = 40'h0 - {{8{prod_mw[31]}}, prod_mw};
          else acca_d = 40'h0 - {{8{prod_mw[31]}}, prod_mw};
        end
        dspx_pkg::OP_MUL, dspx_pkg::OP_MULL: begin
          w_d[cmd_q.rd] = mul_res[15:0];
          w_d[rd1] = mul_res[31:16];
        end
        dspx_pkg::OP_MULF: begin
          case (cmd_q.dst)
            dspx_pkg::DST_FILE: begin
              mem_en = 1'b1;
              mem_we = 1'b1;
              mem_addr = file_q;
              mem_wdata = mul_res[15:0];
            end
            dspx_pkg::DST_WD: begin
              w_d[cmd_q.rd] = mul_res[15:0];
              w_d[rd1] = mul_res[31:16];
            end
            default: begin
              w_d[dspx_pkg::MUL_PAIR] = mul_res[15:0];
              w_d[dspx_pkg::MUL_PAIR + 4'h1] = mul_res[31:16];
            end
          endcase
        end
        dspx_pkg::OP_PUSHF, dspx_pkg::OP_PUSHW, dspx_pkg::OP_PUSHD: begin
          mem_en = 1'b1;
          mem_we = 1'b1;
          mem_wdata = (cmd_q.op == dspx_pkg::OP_PUSHF) ? mem_rdata : w_q[cmd_q.ra];
          sp_d = sp_q + AW'(1);
        end
        dspx_pkg::OP_POPF: begin
          mem_en = 1'b1;
          mem_we = 1'b1;
          mem_addr = file_q;
          mem_wdata = mem_rdata;
          sp_d = sp_q - AW'(1);
        end
        dspx_pkg::OP_POPW: begin
          w_d[cmd_q.rd] = mem_rdata;
          sp_d = sp_q - AW'(1);
        end
        dspx_pkg::OP_POPD: begin
          // top word belongs to the higher register; fetch the lower one now
          w_d[rd1] = mem_rdata;
          sp_d = sp_q - AW'(1);
          mem_en = 1'b1;
          mem_addr = sp_q - AW'(2);
        end
        dspx_pkg::OP_PWR: begin
          watchdog_timeout_flag_d = 1'b0;
          if (lit_q[0]) idle_d = 1'b1;
          else begin
            sleep_d = 1'b1;
            slpf_d = 1'b1;
          end
        end
        dspx_pkg::OP_REPL: rep_d = {2'b00, lit_q};
        dspx_pkg::OP_REPW: rep_d = w_q[cmd_q.ra];
        dspx_pkg::OP_RETURN_WITH_LITERAL: begin
          w_d[cmd_q.rd] = {6'h00, lit_q[9:0]};
          pc_d = mem_rdata;
          sp_d = sp_q - AW'(1);
        end
        default: begin
          // rotates
          fl_d.n = rot_res[15];
          fl_d.z = (rot_res == 16'h0000);
          if (cmd_q.op == dspx_pkg::OP_RLC) fl_d.c = rot_src[15];
          if (cmd_q.op == dspx_pkg::OP_RRC) fl_d.c = rot_src[0];
          case (cmd_q.dst)
            dspx_pkg::DST_FILE: begin
              mem_en = 1'b1;
              mem_we = 1'b1;
              mem_addr = file_q;
              mem_wdata = rot_res;
            end
            dspx_pkg::DST_DEFAULT_WORKING_REGISTER: w_d[dspx_pkg::DEFAULT_WORKING_REGISTER_IDX] = rot_res;
            default: w_d[cmd_q.rd] = rot_res;
          endcase
        end
      endcase
    end else if (st_q == dspx_pkg::ST_EXEC && cnt_q == 2'h1) begin
      if (cmd_q.op == dspx_pkg::OP_POPD) begin
        w_d[cmd_q.rd] = mem_rdata;
        sp_d = sp_q - AW'(1);
      end
      if (cmd_q.op == dspx_pkg::OP_PUSHD) begin
        mem_en = 1'b1;
        mem_we = 1'b1;
        mem_wdata = w_q[cmd_q.ra + 4'h1];
        sp_d = sp_q + AW'(1);
      end
    end
    if (st_q == dspx_pkg::ST_EXEC) cnt_d = cnt_q + 2'h1;
    // the held command reruns while repeats remain
    if (last) begin
      if (rep_q != 16'h0000 && cmd_q.op != dspx_pkg::OP_REPL && cmd_q.op != dspx_pkg::OP_REPW) begin
        rep_d = rep_q - 16'h0001;
        st_d = dspx_pkg::ST_FETCH;
      end else begin
        st_d = dspx_pkg::ST_IDLE;
      end
    end
    // watchdog event wins over any clear in the same cycle
    if (wdt_timeout_i) watchdog_timeout_flag_d = 1'b1;
    busy_d = (st_d != dspx_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= dspx_pkg::ST_IDLE;
      {cmd_q, fl_q, acca_q, accb_q, lit_q, file_q, pc_q, rep_q, cnt_q} <= '0;
      sp_q <= dspx_pkg::SP_RESET;
      for (int i = 0; i < 16; i++) w_q[i] <= 16'h0000;
      {ack_q, busy_q, sleep_q, idle_q, slpf_q, watchdog_timeout_flag_q, dat_q} <= '0;
    end else begin
      st_q <= st_d;
      {cmd_q, fl_q, acca_q, accb_q, lit_q, file_q, pc_q, rep_q, cnt_q} <=
        {cmd_d, fl_d, acca_d, accb_d, lit_d, file_d, pc_d, rep_d, cnt_d};
      sp_q <= sp_d;
      w_q <= w_d;
      {ack_q, busy_q, sleep_q, idle_q, slpf_q, watchdog_timeout_flag_q, dat_q} <=
        {ack_d, busy_d, sleep_d, idle_d, slpf_d, watchdog_timeout_flag_d, dat_d};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign busy_o = busy_q;
  assign sleep_o = sleep_q;
  assign idle_o = idle_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  mpy_result_a: assert property ((first && cmd_q.op == dspx_pkg::OP_MPY && !cmd_q.acc)
    |=> acca_q == {{8{$past(prod_mw[31])}}, $past(prod_mw)}) else $error("mpy result wrong");
  sqr_result_a: assert property ((first && cmd_q.op == dspx_pkg::OP_SQR && cmd_q.acc)
    |=> accb_q == {{8{$past(prod_sq[31])}}, $past(prod_sq)}) else $error("square result wrong");
  mpyn_flags_a: assert property ((first && cmd_q.op == dspx_pkg::OP_MPYN)
    |=> $stable(fl_q)) else $error("negated product touched flags");
  msc_summary_a: assert property ((first && cmd_q.op == dspx_pkg::OP_MSC)
    |=> fl_q.acc_either_overflow == (fl_q.oa | fl_q.ob) && fl_q.acc_either_saturated == (fl_q.sa | fl_q.sb))
    else $error("msc summary flags wrong");
  mul_pair_a: assert property ((first && cmd_q.op == dspx_pkg::OP_MUL)
    |=> {w_q[$past(rd1)], w_q[$past(cmd_q.rd)]} == $past(mul_res)) else $error("mul pair wrong");
  push_sp_a: assert property ((first && cmd_q.op == dspx_pkg::OP_PUSHW)
    |=> sp_q == $past(sp_q) + AW'(1)) else $error("push did not advance stack");
  popd_len_a: assert property ((st_q == dspx_pkg::ST_FETCH && cmd_q.op == dspx_pkg::OP_POPD)
    |=> st_q == dspx_pkg::ST_EXEC ##1 st_q == dspx_pkg::ST_EXEC ##1 st_q != dspx_pkg::ST_EXEC)
    else $error("double pop length wrong");
  pushd_sp_a: assert property ((st_q == dspx_pkg::ST_FETCH && cmd_q.op == dspx_pkg::OP_PUSHD)
    |-> ##3 sp_q == $past(sp_q, 3) + AW'(2)) else $error("double push stack wrong");
  pwr_sleep_a: assert property ((first && cmd_q.op == dspx_pkg::OP_PWR && !lit_q[0])
    |=> sleep_o && slpf_q) else $error("sleep not entered");
  return_with_literal_len_a: assert property ((st_q == dspx_pkg::ST_FETCH && cmd_q.op == dspx_pkg::OP_RETURN_WITH_LITERAL
    && !cmd_q.ret_short) |=> (st_q == dspx_pkg::ST_EXEC)[*3] ##1 st_q != dspx_pkg::ST_EXEC)
    else $error("return length wrong");
  rlc_carry_a: assert property ((first && cmd_q.op == dspx_pkg::OP_RLC)
    |=> fl_q.c == $past(rot_src[15]) && fl_q.n == $past(rot_src[14])) else $error("rlc carry wrong");
endmodule : dspx_core
`default_nettype wire

//--- rtl/dspx_mem.sv
// single port data memory holding file registers and the software stack
`timescale 1ns/1ps
`default_nettype none
module dspx_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // clock
  input wire logic clk_sys_i,
  // access port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [1<<AW];
  logic [DW-1:0] rdata_q;

  // read data registered, no reset so it maps onto block ram
  always_ff @(posedge clk_sys_i) begin
    if (en_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (en_i && !we_i) begin
      rdata_q <= mem[addr_i];
    end
  end
  assign rdata_o = rdata_q;
endmodule : dspx_mem
`default_nettype wire

//--- rtl/dspx_pkg.sv
// constants, types and register map for the dsp instruction subset core
package dspx_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_LIT = 8'h04;
  localparam logic [7:0] REG_FILE = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_SP = 8'h10;
  localparam logic [7:0] REG_PC = 8'h14;
  localparam logic [7:0] REG_ACCA_LO = 8'h18;
  localparam logic [7:0] REG_ACCA_HI = 8'h1c;
  localparam logic [7:0] REG_ACCB_LO = 8'h20;
  localparam logic [7:0] REG_ACCB_HI = 8'h24;
  localparam logic [7:0] REG_REP = 8'h28;
  localparam logic [1:0] REG_WWIN = 2'b01;
  // status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_SLEEPF = 10;
  localparam int ST_IDLEM = 11;
  localparam int ST_WATCHDOG_TIMEOUT_FLAG = 12;
  // fixed register indices and reset values
  localparam logic [3:0] DEFAULT_WORKING_REGISTER_IDX = 4'h0;
  localparam logic [3:0] MUL_PAIR = 4'h2;
  localparam logic [3:0] AWB_IDX = 4'hd;
  localparam logic [7:0] SP_RESET = 8'h80;
  // execute cycles per instruction
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_RET = 2'h3;
  localparam logic [1:0] CYC_RET_SHORT = 2'h2;

  typedef enum logic [4:0] {
    OP_MPY = 5'h00, OP_SQR = 5'h01, OP_MPYN = 5'h02, OP_MSC = 5'h03,
    OP_MUL = 5'h04, OP_MULL = 5'h05, OP_MULF = 5'h06, OP_PUSHF = 5'h07,
    OP_PUSHW = 5'h08, OP_POPF = 5'h09, OP_POPW = 5'h0a, OP_POPD = 5'h0b,
    OP_PUSHD = 5'h0c, OP_PWR = 5'h0d, OP_REPL = 5'h0e, OP_REPW = 5'h0f,
    OP_RETURN_WITH_LITERAL = 5'h10, OP_RLC = 5'h11, OP_ROTATE_LEFT_PLAIN = 5'h12, OP_RRC = 5'h13
  } dspx_op_t;

  typedef enum logic [1:0] {
    DST_FILE = 2'b00, DST_DEFAULT_WORKING_REGISTER = 2'b01, DST_WD = 2'b10
  } dspx_dst_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_EXEC = 2'b10
  } dspx_state_t;

  // command word as written to REG_CMD
  typedef struct packed {
    logic ret_short;
    logic awb;
    logic sgn_a;
    logic sgn_b;
    logic [7:0] rsv;
    logic [3:0] rd;
    logic [3:0] rb;
    logic [3:0] ra;
    dspx_dst_t dst;
    logic acc;
    dspx_op_t op;
  } dspx_cmd_t;

  // status flags, c/n/z in bits 3:1, accumulator flags in 9:4
  typedef struct packed {
    logic acc_either_saturated;
    logic sb;
    logic sa;
    logic acc_either_overflow;
    logic ob;
    logic oa;
    logic z;
    logic n;
    logic c;
  } dspx_flags_t;
endpackage : dspx_pkg
